// *** shared/sps_pkg.sv ***
// constants shared by the card power-down sequencer and its step timer
// assumes a single 100 MHz reference clock for all logic
package sps_pkg;

   // reference clock and slow step period
   localparam int unsigned REF_CLK_HZ   = 100_000_000; // ref_clk_i rate
   localparam int unsigned SLOW_CLK_HZ  = 32_000;      // slow_reference_clock, typical
   // one slow period in reference cycles: 31.25 us -> 3125 cycles
   localparam int unsigned STEP_CYCLES  = REF_CLK_HZ / SLOW_CLK_HZ;
   localparam int unsigned STEP_CNT_W   = $clog2(STEP_CYCLES);

   // serial display link defaults
   localparam int unsigned SER_WORD_W   = 8;  // bits per serial word
   localparam int unsigned SER_DIV      = 4;  // ref cycles per serial clock half
   localparam int unsigned SER_DIV_W    = 3;

   // card line and done levels after reset (card powered off)
   localparam logic        CARD_LINE_RST = 1'h0;
   localparam logic        DONE_RST      = 1'h1;

   // sequencer states
   typedef enum logic [2:0] {
      SPS_OFF     = 3'h0, // all card lines low, done shown
      SPS_ACTIVE  = 3'h1, // card powered, lines follow user levels
      SPS_RST_LOW = 3'h2, // reset low, waiting to stop clock
      SPS_CLK_LOW = 3'h3, // clock low, waiting to drop tx
      SPS_TX_LOW  = 3'h4  // tx low, waiting to drop supply
   } sps_state_t;

endpackage

// *** shared/sps_step_if.sv ***
// carrier between the sequencer and its slow-period step timer
// assumes both ends share ref_clk_i and rst_n_i
`timescale 1ns/1ps
interface sps_step_if;
   logic run;  // timer counts while high
   logic tick; // one-cycle pulse at each full slow period

   modport seq   (output run, input tick);
   modport timer (input run, output tick);
endinterface

// *** rtl/sps_step_timer.sv ***
// step timer: one tick per slow reference period while run is held
// assumes run is driven from a flip-flop in the same clock domain
`timescale 1ns/1ps
module sps_step_timer #(
   parameter int unsigned STEP = sps_pkg::STEP_CYCLES // cycles per step
) (
   input  wire logic   ref_clk_i, // 100 MHz reference
   input  wire logic   rst_n_i,   // async reset, active low
   sps_step_if.timer   step       // run in, tick out
);
   localparam logic [sps_pkg::STEP_CNT_W-1:0] LAST =
      sps_pkg::STEP_CNT_W'(STEP - 1); // terminal count

   logic [sps_pkg::STEP_CNT_W-1:0] cnt_q; // cycles into current step

   // tick lands exactly STEP edges after run rises, then every STEP
   assign step.tick = step.run && (cnt_q == LAST);

   // counter restarts whenever run drops so every sequence starts aligned
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_q <= '0;
      end else if (!step.run || step.tick) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_q + 1'b1;
      end
   end
endmodule

// *** rtl/sps_sequencer.sv ***
// card interface power-down sequencer with a four-wire serial display sender
// assumes all inputs synchronous to ref_clk_i; presence high means card seated
`timescale 1ns/1ps

module sps_sequencer #(
   parameter int unsigned WORD_W = sps_pkg::SER_WORD_W // serial word width
) (
   input  wire logic              ref_clk_i,              // 100 MHz reference
   input  wire logic              rst_n_i,                // async reset, active low
   input  wire logic              card_presence_detect_i, // high while card seated
   input  wire logic              activate_i,             // pulse: power the card up
   input  wire logic              sw_power_down_i,        // pulse: software power-down
   input  wire logic              rst_level_i,            // card reset level while active
   input  wire logic              clk_level_i,            // card clock level while active
   input  wire logic              tx_level_i,             // card tx level while active
   input  wire logic              ser_valid_i,            // serial word offered
   input  wire logic [WORD_W-1:0] ser_word_i,             // serial word, msb first
   input  wire logic              ser_register_select_i,  // register select for the word
   input  wire logic              ser_last_i,             // word ends the burst
   output logic                   card_reset_o,           // card reset line
   output logic                   card_clk_o,             // card clock line
   output logic                   card_tx_o,              // card transmit data line
   output logic                   card_supply_en_o,       // card supply enable
   output logic                   pd_done_o,              // high once card fully off
   output logic                   active_o,               // high in the active state; falls at the power-down trigger while supply is still on
   output logic                   ser_ready_o,            // word accepted on the previous edge
   output logic                   ser_cs_n_o,             // display chip select, low active
   output logic                   ser_clk_o,              // display serial clock
   output logic                   ser_data_o,             // display serial data
   output logic                   register_select_o       // display register select
);

   sps_step_if step (); // carrier to the step timer

   sps_step_timer u_timer (
      .ref_clk_i (ref_clk_i),
      .rst_n_i   (rst_n_i),
      .step      (step.timer)
   );

   sps_pkg::sps_state_t state_q; // sequencer state
   logic                run_q;   // timer enable
   logic                pd_trig; // any power-down request

   // removal or software command while powered; both share one path
   assign pd_trig = (state_q == sps_pkg::SPS_ACTIVE) &&
                    (!card_presence_detect_i || sw_power_down_i);
   assign step.run = run_q;

   // sequencer: one step per tick; requests mid-sequence are ignored
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q <= sps_pkg::SPS_OFF;
      end else begin
         unique case (state_q)
            sps_pkg::SPS_OFF: begin
               // no point powering an empty socket
               if (activate_i && card_presence_detect_i) begin
                  state_q <= sps_pkg::SPS_ACTIVE;
               end
            end
            sps_pkg::SPS_ACTIVE: begin
               if (pd_trig) begin
                  state_q <= sps_pkg::SPS_RST_LOW;
               end
            end
            sps_pkg::SPS_RST_LOW: begin
               if (step.tick) begin
                  state_q <= sps_pkg::SPS_CLK_LOW;
               end
            end
            sps_pkg::SPS_CLK_LOW: begin
               if (step.tick) begin
                  state_q <= sps_pkg::SPS_TX_LOW;
               end
            end
            sps_pkg::SPS_TX_LOW: begin
               if (step.tick) begin
                  state_q <= sps_pkg::SPS_OFF;
               end
            end
            default: begin
               // spare codes fall back to the safe off state
               state_q <= sps_pkg::SPS_OFF;
            end
         endcase
      end
   end

   // timer runs from the reset step until supply drops
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         run_q <= 1'b0;
      end else if (pd_trig) begin
         run_q <= 1'b1;
      end else if (state_q == sps_pkg::SPS_TX_LOW && step.tick) begin
         run_q <= 1'b0;
      end
   end

   // card reset: follows user while active, falls on the trigger edge
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         card_reset_o <= sps_pkg::CARD_LINE_RST;
      end else if (state_q == sps_pkg::SPS_ACTIVE && !pd_trig) begin
         card_reset_o <= rst_level_i;
      end else begin
         card_reset_o <= 1'b0;
      end
   end

   // card clock: stops one full period after reset, so >= 0.9 period holds
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         card_clk_o <= sps_pkg::CARD_LINE_RST;
      end else if (state_q == sps_pkg::SPS_ACTIVE && !pd_trig) begin
         card_clk_o <= clk_level_i;
      end else if (state_q == sps_pkg::SPS_ACTIVE ||
                   (state_q == sps_pkg::SPS_RST_LOW && !step.tick)) begin
         // trigger edge and first step: frozen level, not yet forced low
         card_clk_o <= card_clk_o;
      end else begin
         card_clk_o <= 1'b0;
      end
   end

   // card tx: falls two periods after reset
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         card_tx_o <= sps_pkg::CARD_LINE_RST;
      end else if (state_q == sps_pkg::SPS_ACTIVE && !pd_trig) begin
         card_tx_o <= tx_level_i;
      end else if (state_q == sps_pkg::SPS_ACTIVE || state_q == sps_pkg::SPS_RST_LOW ||
                   (state_q == sps_pkg::SPS_CLK_LOW && !step.tick)) begin
         // trigger edge and first two steps: held, so tx never beats reset
         card_tx_o <= card_tx_o;
      end else begin
         card_tx_o <= 1'b0;
      end
   end

   // supply enable: last to fall, three periods after reset
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         card_supply_en_o <= sps_pkg::CARD_LINE_RST;
      end else if (state_q == sps_pkg::SPS_OFF) begin
         card_supply_en_o <= activate_i && card_presence_detect_i;
      end else if (state_q == sps_pkg::SPS_TX_LOW && step.tick) begin
         card_supply_en_o <= 1'b0;
      end
   end

   // done and active flags for the processor
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pd_done_o <= sps_pkg::DONE_RST;
         active_o  <= 1'b0;
      end else if (state_q == sps_pkg::SPS_OFF) begin
         // done stays up until a real activation is taken
         pd_done_o <= !(activate_i && card_presence_detect_i);
         active_o  <= activate_i && card_presence_detect_i;
      end else if (state_q == sps_pkg::SPS_TX_LOW && step.tick) begin
         pd_done_o <= 1'b1;
         active_o  <= 1'b0;
      end else if (pd_trig) begin
         active_o  <= 1'b0;
      end
   end

   // four-wire serial display sender
   localparam logic [sps_pkg::SER_DIV_W-1:0] DIV_LAST =
      sps_pkg::SER_DIV_W'(sps_pkg::SER_DIV - 1);
   localparam int unsigned BIT_W = $clog2(WORD_W + 1);

   logic [WORD_W-1:0]              shift_q; // word being sent
   logic [BIT_W-1:0]               bits_q;  // bits still to send
   logic [sps_pkg::SER_DIV_W-1:0]  div_q;   // half-period divider
   logic                           last_q;  // current word closes the burst
   logic                           half_end;
   logic                           word_end;
   logic                           load;

   assign half_end = (div_q == DIV_LAST);
   // word ends after the rising-edge half of its final bit
   assign word_end = (bits_q == BIT_W'(1)) && ser_clk_o && half_end;
   // load only when idle or exactly at a word boundary inside the burst
   assign load = ser_valid_i &&
                 ((ser_cs_n_o && bits_q == '0) || (word_end && !last_q));

   // divider free-runs while a word is in flight
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         div_q <= '0;
      end else if (bits_q == '0 || half_end) begin
         div_q <= '0;
      end else begin
         div_q <= div_q + 1'b1;
      end
   end

   // shifter, bit count and serial clock; data changes on the falling half
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         shift_q   <= '0;
         bits_q    <= '0;
         last_q    <= 1'b0;
         ser_clk_o <= 1'b0;
      end else if (load) begin
         shift_q   <= ser_word_i;
         bits_q    <= BIT_W'(WORD_W);
         last_q    <= ser_last_i;
         ser_clk_o <= 1'b0;
      end else if (bits_q != '0 && half_end) begin
         ser_clk_o <= !ser_clk_o;
         if (ser_clk_o) begin
            shift_q <= {shift_q[WORD_W-2:0], 1'b0};
            bits_q  <= bits_q - 1'b1;
         end
      end
   end

   // data, chip select, ready; burst ends when a word runs out unfollowed
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ser_data_o  <= 1'b0;
         ser_cs_n_o  <= 1'b1;
         ser_ready_o <= 1'b0;
      end else begin
         ser_ready_o <= load;
         if (load) begin
            ser_data_o <= ser_word_i[WORD_W-1];
            ser_cs_n_o <= 1'b0;
         end else if (word_end) begin
            ser_data_o <= 1'b0;
            ser_cs_n_o <= 1'b1;
         end else if (bits_q != '0 && half_end && ser_clk_o) begin
            ser_data_o <= shift_q[WORD_W-2];
         end
      end
   end

   // register select is latched only with a new word, never mid-word
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         register_select_o <= 1'b0;
      end else if (load) begin
         register_select_o <= ser_register_select_i;
      end
   end

endmodule

// *** tb/sps_card_model.sv ***
// card socket model: presence switch and a watch on the card line order
// assumes card lines come straight from the sequencer, same clock
`timescale 1ns/1ps
module sps_card_model (
   input  wire logic ref_clk_i,              // reference clock
   input  wire logic rst_n_i,                // async reset, active low
   input  wire logic seated_i,               // bench: card in socket
   input  wire logic card_reset_i,           // card reset line
   input  wire logic card_clk_i,             // card clock line
   input  wire logic card_tx_i,              // card transmit line
   input  wire logic card_supply_en_i,       // card supply enable
   output logic      card_presence_detect_o, // presence switch level
   output logic      order_err_o             // a line was high without supply
);
   // switch opens at once on removal; no debounce modelled
   assign card_presence_detect_o = seated_i;
   // a card line high with supply off means supply fell too early
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         order_err_o <= 1'h0;
      end else if (!card_supply_en_i && (card_reset_i || card_clk_i || card_tx_i)) begin
         order_err_o <= 1'h1;
      end
   end
endmodule

// *** tb/sps_seq_monitor.sv ***
// port checker for the card power-down sequencer
// assumes it is bound onto sps_sequencer, single clock domain
`timescale 1ns/1ps
module sps_seq_monitor (
   input wire logic ref_clk_i,              // reference clock
   input wire logic rst_n_i,                // async reset, active low
   input wire logic card_presence_detect_i, // card seated
   input wire logic activate_i,             // power-up pulse
   input wire logic sw_power_down_i,        // software power-down
   input wire logic card_reset_o,           // card reset
   input wire logic card_clk_o,             // card clock
   input wire logic card_tx_o,              // card tx
   input wire logic card_supply_en_o,       // card supply
   input wire logic pd_done_o,              // fully off
   input wire logic active_o,               // card powered
   input wire logic ser_ready_o,            // word taken
   input wire logic ser_cs_n_o,             // display select
   input wire logic ser_clk_o,              // display clock
   input wire logic ser_data_o,             // display data
   input wire logic register_select_o       // display register select
);
   localparam int STP = sps_pkg::STEP_CYCLES; // cycles per slow period
   logic [15:0] pd_cnt_q; // cycles since power-down began
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   // count from the edge after active falls until done shows
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pd_cnt_q <= 16'h0000;
      end else if ($fell(active_o) && !pd_done_o) begin
         pd_cnt_q <= 16'h0001;
      end else if (pd_cnt_q != 16'h0000 && !pd_done_o) begin
         pd_cnt_q <= pd_cnt_q + 16'h0001;
      end else begin
         pd_cnt_q <= 16'h0000;
      end
   end
   rm_start_a: assert property (active_o && !card_presence_detect_i |=> !card_reset_o && !active_o)
      else $error("removal did not drop card reset");
   sw_start_a: assert property (active_o && sw_power_down_i |=> !card_reset_o && !active_o)
      else $error("software command did not drop card reset");
   rst_low_a: assert property (pd_cnt_q != 0 |-> !card_reset_o)
      else $error("card reset rose during power-down");
   // the counter starts one edge late, so the trigger edge itself is watched here
   trig_hold_a: assert property (active_o && (!card_presence_detect_i || sw_power_down_i)
      |=> $stable(card_clk_o) && $stable(card_tx_o))
      else $error("card clock or tx fell together with reset");
   clk_step_a: assert property (pd_cnt_q >= 1 && pd_cnt_q < STP |-> $stable(card_clk_o))
      else $error("card clock moved before one period");
   clk_stop_a: assert property (pd_cnt_q == STP |-> !card_clk_o)
      else $error("card clock not stopped after one period");
   tx_step_a: assert property (pd_cnt_q >= 1 && pd_cnt_q < 2*STP |-> $stable(card_tx_o))
      else $error("card tx moved before two periods");
   tx_low_a: assert property (pd_cnt_q == 2*STP |-> !card_tx_o)
      else $error("card tx not low after two periods");
   sup_step_a: assert property (pd_cnt_q >= 1 && pd_cnt_q < 3*STP |-> card_supply_en_o && !pd_done_o)
      else $error("supply dropped before three periods");
   sup_off_a: assert property (pd_cnt_q == 3*STP |-> !card_supply_en_o && pd_done_o)
      else $error("supply or done wrong after three periods");
   off_hold_a: assert property (pd_done_o && !activate_i |=> pd_done_o && !card_reset_o
      && !card_clk_o && !card_tx_o && !card_supply_en_o)
      else $error("card lines not held off");
   sel_word_a: assert property (!ser_cs_n_o && $changed(register_select_o) |-> ser_ready_o)
      else $error("register select changed inside a word");
   sclk_half_a: assert property ($rose(ser_clk_o) |-> ser_clk_o [*4] ##1 !ser_clk_o)
      else $error("serial clock high half not four cycles");
   // main scenarios reached
   pd_full_c: cover property (pd_cnt_q == 3*STP);
   rm_c: cover property (active_o && !card_presence_detect_i);
   b2b_c: cover property (ser_ready_o && $past(!ser_cs_n_o));
endmodule
bind sps_sequencer sps_seq_monitor i_sps_seq_monitor (
   .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .card_presence_detect_i(card_presence_detect_i),
   .activate_i(activate_i), .sw_power_down_i(sw_power_down_i), .card_reset_o(card_reset_o),
   .card_clk_o(card_clk_o), .card_tx_o(card_tx_o), .card_supply_en_o(card_supply_en_o),
   .pd_done_o(pd_done_o), .active_o(active_o), .ser_ready_o(ser_ready_o),
   .ser_cs_n_o(ser_cs_n_o), .ser_clk_o(ser_clk_o), .ser_data_o(ser_data_o),
   .register_select_o(register_select_o));

// *** tb/tb_top.sv ***
// testbench: power-down by removal and by command, refusals, serial burst
// assumes the sequencer with its default step of one slow period
`timescale 1ns/1ps
module tb_top;
   localparam int STP = sps_pkg::STEP_CYCLES; // cycles per slow period
   logic ref_clk_i, rst_n_i, seated, pres, act, swpd, lvl, oerr;            // control
   logic c_rst, c_clk, c_tx, c_sup, done, active;                           // card side
   logic s_val, s_sel, s_last, s_rdy, cs_n, sclk, sdat, sel_o, sclk_q;      // serial side
   logic [7:0]  s_word;  // word offered
   logic [15:0] bits, selq; // captured data and select per bit
   int errors, n_compared, cycles, nb, nr;                                  // counters
   sps_sequencer i_sps_sequencer (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
      .card_presence_detect_i(pres), .activate_i(act), .sw_power_down_i(swpd),
      .rst_level_i(lvl), .clk_level_i(lvl), .tx_level_i(lvl), .ser_valid_i(s_val),
      .ser_word_i(s_word), .ser_register_select_i(s_sel), .ser_last_i(s_last),
      .card_reset_o(c_rst),
      .card_clk_o(c_clk), .card_tx_o(c_tx), .card_supply_en_o(c_sup), .pd_done_o(done),
      .active_o(active), .ser_ready_o(s_rdy), .ser_cs_n_o(cs_n), .ser_clk_o(sclk),
      .ser_data_o(sdat), .register_select_o(sel_o));
   sps_card_model i_sps_card_model (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
      .seated_i(seated), .card_reset_i(c_rst), .card_clk_i(c_clk), .card_tx_i(c_tx),
      .card_supply_en_i(c_sup), .card_presence_detect_o(pres), .order_err_o(oerr));
   // clock, 10 ns period
   initial begin
      ref_clk_i = 1'h0;
      forever #5 ref_clk_i = ~ref_clk_i;
   end
   // watch serial clock rises, ready pulses and the run limit
   always @(posedge ref_clk_i) begin
      sclk_q <= sclk;
      if (sclk && !sclk_q) begin
         bits <= {bits[14:0], sdat};
         selq <= {selq[14:0], sel_o};
         nb++;
      end
      if (s_rdy) nr++;
      cycles++;
      if (cycles == 40000) begin
         errors++; // hang
         stop_test();
      end
   end
   task automatic cyc(); // inputs move 1 ns after the edge
      @(posedge ref_clk_i);
      #1;
   endtask
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("Error %s expected %0h seen %0h", name, exp, seen);
      end
   endtask
   task automatic t_up(); // power the card, prove lines follow levels, end high
      act = 1'h1;
      cyc();
      act = 1'h0;
      check("up", {c_sup, active, done}, 3'h6);
      cyc();
      check("lines", {c_rst, c_clk, c_tx}, 3'h7);
      lvl = 1'h0;
      cyc();
      check("lines_low", {c_rst, c_clk, c_tx, c_sup}, 4'h1);
      lvl = 1'h1;
      cyc();
   endtask
   task automatic t_down(input bit by_sw); // trigger, then time each fall
      int k, tc, tt, ts;
      if (by_sw) swpd = 1'h1;
      else seated = 1'h0;
      cyc();
      swpd = 1'h0;
      k = 0; tc = 0; tt = 0; ts = 0;
      check("rst_low", {c_rst, active, c_clk}, 3'h1);
      while (ts == 0 && k < 3*STP + 20) begin
         cyc();
         k++;
         if (tc == 0 && c_clk !== 1'h1) tc = k;
         if (tt == 0 && c_tx !== 1'h1) tt = k;
         if (c_sup !== 1'h1) ts = k;
      end
      check("clk_time", tc, STP);
      check("tx_time", tt, 2*STP);
      check("sup_time", ts, 3*STP);
      check("done", {done, oerr}, 2'h2);
      act = !by_sw; // refused when absent
      swpd = by_sw; // refused outside active
      cyc();
      act = 1'h0;
      swpd = 1'h0;
      cyc();
      check("refused", {done, c_sup}, 2'h2);
      seated = 1'h1;
   endtask
   task automatic send(input logic [7:0] w, input logic r, input logic l); // one word
      int n;
      s_val = 1'h1;
      s_word = w;
      s_sel = r;
      s_last = l;
      n = 0;
      while (s_rdy !== 1'h1 && n < 200) begin
         cyc();
         n++;
      end
      cyc();
      // valid stays up inside a burst so it is never lowered and raised in one step
      if (l) s_val = 1'h0;
   endtask
   task automatic t_serial(); // two-word burst with a select change
      int n;
      nb = 0; nr = 0;
      send(8'hA5, 1'h0, 1'h0);
      send(8'h3C, 1'h1, 1'h1);
      n = 0;
      while (cs_n !== 1'h1 && n < 200) begin
         cyc();
         n++;
      end
      cyc();
      check("bits", bits, 16'hA53C);
      check("sel", selq, 16'h00FF);
      check("counts", {nb[7:0], nr[7:0]}, 16'h1002);
   endtask
   task automatic stop_test();
      $display("checks %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // main sequence
   initial begin
      rst_n_i = 1'h0; seated = 1'h1; act = 1'h0; swpd = 1'h0; lvl = 1'h1;
      s_val = 1'h0;
      s_word = 8'h00;
      s_sel = 1'h0;
      s_last = 1'h0;
      sclk_q = 1'h0;
      bits = 16'h0000;
      selq = 16'h0000;
      errors = 0; n_compared = 0; cycles = 0; nb = 0; nr = 0;
      repeat (10) @(posedge ref_clk_i);
      #1 rst_n_i = 1'h1;
      check("reset", {done, c_rst, c_clk, c_tx, c_sup, cs_n}, 6'h21);
      cyc();
      t_up();
      t_down(1'b0);
      t_up();
      t_down(1'b1);
      t_serial();
      stop_test();
   end
endmodule
